// [hdl/adc_seq_consts.vh]
// Constants for the converter sequencer: offsets, fields, reset values, timing
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// Register word offsets (Avalon word addresses, matched against avs_address directly)
`define OFS_MODE0 4'h0
`define OFS_CHSEL 4'h1
`define OFS_STATUS 4'h2
`define OFS_RESULT 4'h3
`define OFS_RESULT_HI 4'h4

// Mode register 0 fields
`define MODE0_START_BIT 7
`define MODE0_SCAN_BIT 6
`define MODE0_ONESHOT_BIT 3
`define MODE0_ENABLE_BIT 0

// Reset values
`define MODE0_RESET 8'h00
`define CHSEL_RESET 8'h00
`define RESULT_RESET 16'h0000
`define RESULT_HI_RESET 8'h00

// Result scaling: approximation value times 64 is a left shift by 6
`define RESULT_SHIFT 6
`define SAR_BITS 10

// Conversion timing: one comparison step per bit plus sampling
`define SAMPLE_CYCLES 8'h10
`define STEP_CYCLES 8'h04

// Software settling wait before start, in ns, and its cycle count at 250 MHz
`define STAB_WAIT_NS 1000
`define CLK_PERIOD_NS 4
`define STAB_WAIT_CYCLES ((`STAB_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [hdl/adc_result_store.v]
// Result word and high-byte result holding registers
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"

module adc_result_store (
  input wire ref_clk,
  input wire rstn,
  input wire store,
  input wire [9:0] approx,
  output reg [15:0] result_word,
  output reg [7:0] result_high_byte
);

  // ----------------------------------------------------------------
  // Left-justified store
  // ----------------------------------------------------------------
  // Result is approximation times 64; high byte is the top eight bits
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      result_word <= `RESULT_RESET;
      result_high_byte <= `RESULT_HI_RESET;
    end else if (store) begin
      result_word <= {approx, 6'h00};
      result_high_byte <= approx[9:2];
    end
  end

endmodule // adc_result_store
`default_nettype wire

// [hdl/adc_sar_core.v]
// Successive approximation bit-search driving the comparator
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"

module adc_sar_core #(
  parameter [7:0] SAMPLE_CYCLES = `SAMPLE_CYCLES,
  parameter [7:0] STEP_CYCLES = `STEP_CYCLES
) (
  input wire ref_clk,
  input wire rstn,
  input wire start,
  input wire abort,
  input wire cmp_high,
  output reg sampling,
  output reg [9:0] trial,
  output reg done,
  output reg [9:0] approx
);

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_SAMPLE = 2'h1;
  localparam [1:0] S_STEP = 2'h2;

  reg [1:0] st_q;
  reg [7:0] cnt_q;
  reg [3:0] bit_q;

  // ----------------------------------------------------------------
  // Bit search
  // ----------------------------------------------------------------
  // Start wins over abort so a restart never loses a cycle
  // The tap reaches the pin one cycle late, so STEP_CYCLES below 2 compares a stale tap
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= S_IDLE;
      cnt_q <= 8'h00;
      bit_q <= 4'h0;
      sampling <= 1'b0;
      trial <= 10'h000;
      done <= 1'b0;
      approx <= 10'h000;
    end else begin
      done <= 1'b0;
      if (start) begin
        st_q <= S_SAMPLE;
        cnt_q <= SAMPLE_CYCLES;
        sampling <= 1'b1;
        trial <= 10'h000;
      end else if (abort) begin
        st_q <= S_IDLE; // Partial bits dropped, never stored
        sampling <= 1'b0;
        trial <= 10'h000;
      end else begin
        case (st_q)
          S_IDLE: begin
            sampling <= 1'b0;
          end
          S_SAMPLE: begin
            if (cnt_q == 8'h01) begin
              sampling <= 1'b0;
              st_q <= S_STEP;
              bit_q <= 4'h9;
              trial <= 10'h200;
              cnt_q <= STEP_CYCLES;
            end else begin
              cnt_q <= cnt_q - 8'h01;
            end
          end
          S_STEP: begin
            if (cnt_q == 8'h01) begin
              // Keep trial bit only if input is at or above the tap
              if (!cmp_high)
                trial[bit_q] <= 1'b0;
              if (bit_q == 4'h0) begin
                st_q <= S_IDLE;
                done <= 1'b1;
                approx <= cmp_high ? trial : (trial & 10'h3fe);
              end else begin
                bit_q <= bit_q - 4'h1;
                trial[bit_q - 4'h1] <= 1'b1;
                cnt_q <= STEP_CYCLES;
              end
            end else begin
              cnt_q <= cnt_q - 8'h01;
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

endmodule // adc_sar_core
`default_nettype wire

// [hdl/adc_sw_trigger_seq.v]
// Software-trigger converter sequencer with Avalon-MM register slave
// Summary of operation
// - Result is approximation value times sixty-four
// - Enable from stop enters standby, no conversion
// - Select mode start converts the selected channel
// - Each end stores word, high byte, raises irq
// - Select sequential repeats while start stays set
// - One-shot clears start, returns to standby
// - Start rewrite mid-conversion discards and restarts
// - Channel write mid-conversion restarts on new channel
// - Hardware trigger ignored during sequential conversion
// - Clearing start mid-conversion aborts to standby
// - Clearing enable in standby enters stop
// - Start ignored while enable is zero
// - Hardware trigger ignored in one-shot standby
// - Scan converts four slots in fixed order
// - Scan sequential stores and interrupts per channel
// - Scan start rewrite restarts at first slot
// - Scan channel write restarts new group slot
// - Start is bit seven of mode register
// - Reset clears result word and high byte
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"

module adc_sw_trigger_seq #(
  parameter [7:0] SAMPLE_CYCLES = `SAMPLE_CYCLES,
  parameter [7:0] STEP_CYCLES = `STEP_CYCLES
) (
  input wire ref_clk,
  input wire rstn,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire hw_trigger,
  input wire cmp_high,
  output reg sample_hold,
  output reg [9:0] dac_tap,
  output reg [4:0] analog_channel,
  output reg conversion_end_irq,
  output reg converter_powered
);

  // State codes
  localparam [1:0] ST_STOP = 2'h0;
  localparam [1:0] ST_STANDBY = 2'h1;
  localparam [1:0] ST_CONVERT = 2'h2;

  reg [1:0] state_q;
  reg [7:0] converter_mode_reg0;
  reg [7:0] channel_select_reg;
  reg [1:0] slot_q;
  reg ack_q;
  reg kick_q;
  reg abort_q;

  wire sampling;
  wire [9:0] trial;
  wire done;
  wire [9:0] approximation_value;
  wire [15:0] result_word;
  wire [7:0] result_high_byte;

  wire converter_enable_bit = converter_mode_reg0[`MODE0_ENABLE_BIT];
  wire conversion_start_bit = converter_mode_reg0[`MODE0_START_BIT];
  wire scan_mode = converter_mode_reg0[`MODE0_SCAN_BIT];
  wire one_shot = converter_mode_reg0[`MODE0_ONESHOT_BIT];

  // Accepted bus access: one wait cycle, taken when waitrequest is low
  wire acc = (avs_read | avs_write) & ack_q;
  wire wr = avs_write & ack_q & avs_byteenable[0];
  wire wr_mode = wr & (avs_address == `OFS_MODE0);
  wire wr_chsel = wr & (avs_address == `OFS_CHSEL);
  wire new_start = avs_writedata[`MODE0_START_BIT];
  wire new_enable = avs_writedata[`MODE0_ENABLE_BIT];
  wire last_slot = (slot_q == 2'h3);

  // Channel for a slot: scan uses the group base plus slot
  function [4:0] chan_of;
    input [7:0] sel;
    input scan;
    input [1:0] slot;
    begin
      if (scan)
        chan_of = {sel[4:2], slot};
      else
        chan_of = sel[4:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Conversion engine and result holding
  // ----------------------------------------------------------------
  adc_sar_core #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .STEP_CYCLES(STEP_CYCLES)
  ) u_core (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(kick_q),
    .abort(abort_q),
    .cmp_high(cmp_high),
    .sampling(sampling),
    .trial(trial),
    .done(done),
    .approx(approximation_value)
  );

  adc_result_store u_store (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .store(done),
    .approx(approximation_value),
    .result_word(result_word),
    .result_high_byte(result_high_byte)
  );

  // ----------------------------------------------------------------
  // Avalon handshake: every access waits one cycle
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
    end
  end

  // Read mux; unmapped words read zero
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack_q) begin
      case (avs_address)
        `OFS_MODE0: avs_readdata <= {24'h000000, converter_mode_reg0};
        `OFS_CHSEL: avs_readdata <= {24'h000000, channel_select_reg};
        `OFS_STATUS: avs_readdata <= {28'h0000000, slot_q, state_q};
        `OFS_RESULT: avs_readdata <= {16'h0000, result_word};
        `OFS_RESULT_HI: avs_readdata <= {24'h000000, result_high_byte};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Software writes and completions both touch the start bit; the
  // software write takes priority since it is the newer command.
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_STOP;
      converter_mode_reg0 <= `MODE0_RESET;
      channel_select_reg <= `CHSEL_RESET;
      slot_q <= 2'h0;
      kick_q <= 1'b0;
      abort_q <= 1'b0;
      conversion_end_irq <= 1'b0;
    end else begin
      kick_q <= 1'b0;
      abort_q <= 1'b0;
      conversion_end_irq <= done;
      // hw_trigger never reaches the engine in these modes
      if (wr_chsel)
        channel_select_reg <= avs_writedata[7:0];
      if (wr_mode) begin
        // Start bit masked while the converter is disabled
        converter_mode_reg0 <= {new_start & new_enable, avs_writedata[6:0]};
        if (!new_enable) begin
          state_q <= ST_STOP;
          abort_q <= 1'b1;
        end else if (new_start) begin
          state_q <= ST_CONVERT;
          slot_q <= 2'h0;
          kick_q <= 1'b1;
        end else begin
          state_q <= ST_STANDBY;
          abort_q <= 1'b1;
        end
      end else if (wr_chsel && state_q == ST_CONVERT) begin
        slot_q <= 2'h0;
        kick_q <= 1'b1;
      end else if (done && state_q == ST_CONVERT) begin
        if (scan_mode && !last_slot) begin
          slot_q <= slot_q + 2'h1;
          kick_q <= 1'b1;
        end else if (one_shot) begin
          converter_mode_reg0[`MODE0_START_BIT] <= 1'b0;
          state_q <= ST_STANDBY;
          slot_q <= 2'h0;
        end else begin
          slot_q <= 2'h0;
          kick_q <= 1'b1;
        end
      end
      // Trigger input is deliberately unused
    end
  end

  // ----------------------------------------------------------------
  // Analog-side outputs, registered
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sample_hold <= 1'b0;
      dac_tap <= 10'h000;
      analog_channel <= 5'h00;
      converter_powered <= 1'b0;
    end else begin
      sample_hold <= sampling;
      dac_tap <= trial;
      analog_channel <= chan_of(channel_select_reg, scan_mode, slot_q);
      converter_powered <= (state_q != ST_STOP);
    end
  end

  // Unused read of acc and hw_trigger keeps intent visible
  wire unused_ok = acc | hw_trigger | (|avs_writedata[31:8]) | (|avs_byteenable[3:1]);

endmodule // adc_sw_trigger_seq
`default_nettype wire

// [verification/adc_seq_properties.sv]
// Concurrent checks on the converter sequencer ports
`timescale 1ns/1ps
`default_nettype none
module adc_seq_properties (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sample_hold,
  input wire logic conversion_end_irq,
  input wire logic converter_powered
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Bus answers after one wait cycle, then waits again
  answer_one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus answer late");
  wait_release_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  read_width_a: assert property (avs_read && !avs_waitrequest
    |-> avs_readdata[31:16] == 16'h0000) else $error("read upper half not zero");
  // Conversion activity only while enabled
  stop_no_sample_a: assert property (!converter_powered |-> !sample_hold)
    else $error("sampling while stopped");
  irq_needs_power_a: assert property (conversion_end_irq |-> converter_powered)
    else $error("irq while stopped");
  enable_idle_a: assert property ($rose(converter_powered)
    |-> !sample_hold ##1 !sample_hold) else $error("enable started a conversion");
  // Sample-and-hold is low one cycle and ten cycles before every irq
  full_search_a: assert property (conversion_end_irq
    |-> !$past(sample_hold) && !$past(sample_hold, 10)) else $error("search too short");
  irq_one_cycle_a: assert property (conversion_end_irq |=> !conversion_end_irq)
    else $error("irq longer than one cycle");
  cover property (conversion_end_irq);
  cover property ($rose(sample_hold));
  cover property (avs_read && !avs_waitrequest);
endmodule // adc_seq_properties
`default_nettype wire

// [verification/analog_core_model.sv]
// Behavioural sample-and-hold and comparator facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
  input wire logic ref_clk,
  input wire logic sample_hold,
  input wire logic [9:0] dac_tap,
  input wire logic [4:0] analog_channel,
  output logic cmp_high
);
  logic [9:0] held;
  // Track the channel while sampling; frozen through the search
  always @(posedge ref_clk) begin
    if (sample_hold) held <= {analog_channel, 5'h00} ^ 10'h155;
  end
  // Tap at or below the held level keeps the trial bit, so rounding lands on held
  assign cmp_high = (held >= dac_tap);
endmodule // analog_core_model
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the software-trigger converter sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic hw_trigger = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, cmp_high, sample_hold, conversion_end_irq, converter_powered;
  logic [9:0] dac_tap;
  logic [4:0] analog_channel;
  logic [15:0] rv;
  int n_fail = 0;
  int checked = 0;
  int n;
  // Sampling plus ten steps; a restarted conversion needs at least this after the write
  localparam int conv_cycles = 2 + 10 * 2;
  // Short counts keep conversions brief; two-cycle steps let the registered tap settle
  adc_sw_trigger_seq #(.SAMPLE_CYCLES(8'h02), .STEP_CYCLES(8'h02)) DUT (
    .ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .hw_trigger(hw_trigger), .cmp_high(cmp_high), .sample_hold(sample_hold),
    .dac_tap(dac_tap), .analog_channel(analog_channel),
    .conversion_end_irq(conversion_end_irq), .converter_powered(converter_powered));
  analog_core_model core (.ref_clk(ref_clk), .sample_hold(sample_hold),
    .dac_tap(dac_tap), .analog_channel(analog_channel), .cmp_high(cmp_high));
  initial forever #2 ref_clk = ~ref_clk;
  // Trigger events arrive every second cycle; software modes must ignore them
  always @(posedge ref_clk) hw_trigger <= ~hw_trigger;
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic quiet;
    n = 0;
    repeat (40) @(posedge ref_clk) if (conversion_end_irq === 1'b1) n++;
  endtask
  task automatic got(input logic [4:0] c);
    logic [9:0] v;
    v = {c, 5'h00} ^ 10'h155;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (conversion_end_irq !== 1'b1);
    bus(1'b0, 4'h3, 8'h00);
    chk("result_word", rv, {v, 6'h00});
    bus(1'b0, 4'h4, 8'h00);
    chk("result_high_byte", rv, {8'h00, v[9:2]});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    bus(1'b0, 4'h3, 8'h00); chk("result_word", rv, 16'h0000);
    bus(1'b0, 4'h4, 8'h00); chk("result_high_byte", rv, 16'h0000);
    bus(1'b0, 4'h9, 8'h00); chk("unmapped", rv, 16'h0000);
    $display("end of test: reset");
    bus(1'b1, 4'h0, 8'h80); quiet; chk("irq count", n[15:0], 16'h0);
    bus(1'b0, 4'h2, 8'h00); chk("state", rv & 16'h3, 16'h0);
    bus(1'b1, 4'h0, 8'h01);
    bus(1'b0, 4'h2, 8'h00); chk("state", rv & 16'h3, 16'h1);
    repeat (250) @(posedge ref_clk); // settling wait of one microsecond
    bus(1'b1, 4'h1, 8'h05); bus(1'b1, 4'h0, 8'h89); got(5'd5);
    quiet; chk("irq count", n[15:0], 16'h0);
    bus(1'b0, 4'h0, 8'h00); chk("start bit", rv & 16'h80, 16'h0);
    bus(1'b0, 4'h2, 8'h00); chk("state", rv & 16'h3, 16'h1);
    $display("end of test: select one-shot");
    bus(1'b1, 4'h0, 8'h81); got(5'd5); got(5'd5);
    bus(1'b1, 4'h1, 8'h09); got(5'd9);
    bus(1'b1, 4'h0, 8'h81); got(5'd9); chk("restart gap", 16'(n >= conv_cycles), 16'h1);
    bus(1'b1, 4'h0, 8'h01); quiet; chk("irq count", n[15:0], 16'h0);
    bus(1'b0, 4'h2, 8'h00); chk("state", rv & 16'h3, 16'h1);
    $display("end of test: select sequential");
    bus(1'b1, 4'h1, 8'h04); bus(1'b1, 4'h0, 8'hc1);
    for (int i = 0; i < 4; i++) got(5'(4 + i));
    got(5'd4); got(5'd5);
    bus(1'b1, 4'h0, 8'hc1); got(5'd4);
    bus(1'b1, 4'h1, 8'h08); got(5'd8);
    bus(1'b1, 4'h0, 8'h01);
    $display("end of test: scan sequential");
    bus(1'b1, 4'h1, 8'h04); bus(1'b1, 4'h0, 8'hc9);
    for (int i = 0; i < 4; i++) got(5'(4 + i));
    quiet; chk("irq count", n[15:0], 16'h0);
    bus(1'b0, 4'h0, 8'h00); chk("start bit", rv & 16'h80, 16'h0);
    bus(1'b1, 4'h0, 8'h00);
    bus(1'b0, 4'h2, 8'h00); chk("state", rv & 16'h3, 16'h0);
    chk("powered", {15'h0, converter_powered}, 16'h0);
    $display("end of test: scan one-shot and stop");
    give_verdict;
  end
  // Cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    give_verdict;
  end
endmodule // testbench
bind adc_sw_trigger_seq adc_seq_properties props (.ref_clk(ref_clk), .rstn(rstn),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .sample_hold(sample_hold),
  .conversion_end_irq(conversion_end_irq), .converter_powered(converter_powered));
`default_nettype wire
